//--- hw/scuc_top.sv
/*
  Asynchronous serial channel pair: channel 0 transmits, channel 1
  receives, both steered by software-written mode, control and divisor
  registers over a plain 16-bit register port.
  Assumes the channel operation clock is clk_sys and the receive pin is
  asynchronous to it.
*/
`timescale 1ns/1ps
`default_nettype none

module scuc_top
  import scuc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [scuc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [scuc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [scuc_pkg::DATA_W-1:0] reg_rdata,
  output logic txd,
  input wire logic rxd,
  output logic tx_irq,
  output logic rx_irq,
  output logic receive_error_irq
);

  typedef struct packed {
    logic [15:0] tx_mode;
    logic [15:0] comm;
    logic [DIV_W-1:0] div;
    logic [CHAR_W-1:0] tx_buf;
    logic tx_buf_full;
    logic [CHAR_W-1:0] tx_sh;
    scuc_tx_state_t tx_state;
    logic [3:0] tx_bit;
    logic tx_stop2;
    logic tx_restart;
    logic [15:0] rx_mode;
    scuc_rx_state_t rx_state;
    logic [3:0] rx_bit;
    logic [CHAR_W-1:0] rx_sh;
    logic rx_perr_now;
    logic rx_stop2;
    logic rx_restart;
    logic [CHAR_W-1:0] rx_data;
    logic rx_valid;
    logic rx_perr;
    logic rx_ferr;
    logic rx_ovr;
    logic rx_armed;
    logic s1;
    logic s2;
    logic s3;
    logic filt;
    logic line_prev;
    logic txd;
    logic tx_irq;
    logic rx_irq;
    logic err_irq;
    logic [15:0] rdata;
  } scuc_state_t;

  scuc_state_t s_q;
  scuc_state_t s_d;
  logic tx_tick;
  logic tx_mid;
  logic rx_tick;
  logic rx_mid;

  function automatic logic [3:0] char_len(input logic [1:0] code);
    // Prohibited length code falls back to eight bits.
    unique case (code)
      LEN_NINE: char_len = 4'd9;
      LEN_SEVEN: char_len = 4'd7;
      default: char_len = 4'd8;
    endcase
  endfunction

  function automatic logic [3:0] bit_pos(input logic [3:0] idx,
                                         input logic [3:0] len,
                                         input logic lsb_first);
    bit_pos = lsb_first ? idx : len - 4'd1 - idx;
  endfunction

  function automatic logic odd_ones(input logic [CHAR_W-1:0] d,
                                    input logic [3:0] len);
    logic [CHAR_W-1:0] m;
    m = 9'h1ff >> (4'd9 - len);
    odd_ones = ^(d & m);
  endfunction

  scuc_bit_timer u_tx_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(s_q.tx_restart),
    .divisor(s_q.div),
    .tick(tx_tick),
    .mid()
  );

  scuc_bit_timer u_rx_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(s_q.rx_restart),
    .divisor(s_q.div),
    .tick(rx_tick),
    .mid(rx_mid)
  );

  assign tx_mid = 1'b0;

  always_comb begin
    logic [3:0] len;
    logic [1:0] par;
    logic [1:0] stop;
    logic lsb;
    logic tx_on;
    logic rx_on;
    logic line;
    logic rx_done;
    logic rd_rx;
    len = char_len(s_q.comm[DLS_LO_POS +: 2]);
    par = s_q.comm[PTC_LO_POS +: 2];
    stop = s_q.comm[SLC_LO_POS +: 2];
    lsb = s_q.comm[DIR_POS];
    // Only the asynchronous mode runs the shifters here.
    tx_on = (s_q.tx_mode[MD_LO_POS +: 2] == MODE_ASYNC) &&
            s_q.comm[TXE_POS];
    rx_on = (s_q.rx_mode[MD_LO_POS +: 2] == MODE_ASYNC) &&
            s_q.comm[RXE_POS];
    line = s_q.filt ^ s_q.rx_mode[SIS_POS];
    rx_done = 1'b0;
    rd_rx = reg_rd && reg_addr == OFS_RX_DATA;
    s_d = s_q;
    s_d.tx_restart = 1'b0;
    s_d.rx_restart = 1'b0;
    s_d.tx_irq = 1'b0;
    s_d.rx_irq = 1'b0;
    s_d.err_irq = 1'b0;
    s_d.rdata = 16'h0000;

    // A change on the pin counts once stages two and three agree.
    s_d.s1 = rxd;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3) begin
      s_d.filt = s_q.s2;
    end
    s_d.line_prev = line;

    if (reg_wr) begin
      unique case (reg_addr)
        OFS_TX_MODE: s_d.tx_mode = (reg_wdata & TX_MODE_WMASK) | MODE_FIXED;
        OFS_TX_COMM: s_d.comm = (reg_wdata & COMM_WMASK) | COMM_FIXED;
        OFS_TX_DATA_DIV: begin
          s_d.div = reg_wdata[DIV_LO_POS +: DIV_W];
          if (!s_q.tx_buf_full) begin
            s_d.tx_buf = reg_wdata[CHAR_W-1:0];
            s_d.tx_buf_full = 1'b1;
          end
        end
        OFS_RX_MODE: s_d.rx_mode = (reg_wdata & RX_MODE_WMASK) | MODE_FIXED;
        OFS_STATUS: begin
          if (reg_wdata[SW_TRIG_POS]) begin
            s_d.rx_armed = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    if (reg_rd) begin
      unique case (reg_addr)
        OFS_TX_MODE: s_d.rdata = s_q.tx_mode;
        OFS_TX_COMM: s_d.rdata = s_q.comm;
        OFS_TX_DATA_DIV: s_d.rdata = {s_q.div, s_q.tx_buf};
        OFS_RX_MODE: s_d.rdata = s_q.rx_mode;
        OFS_RX_DATA: s_d.rdata = {s_q.rx_valid, 3'h0, s_q.rx_ovr,
                                  s_q.rx_ferr, s_q.rx_perr, s_q.rx_data};
        OFS_STATUS: s_d.rdata = {8'h00, s_q.rx_state != RX_IDLE,
          s_q.rx_armed || s_q.rx_mode[STS_POS],
          char_len(s_q.comm[DLS_LO_POS +: 2]) == 4'd8 &&
          s_q.comm[DLS_LO_POS +: 2] == LEN_BAD, stop == STOP_BAD,
          s_q.rx_mode[MD_LO_POS +: 2] == MODE_BAD,
          s_q.tx_mode[MD_LO_POS +: 2] == MODE_BAD,
          s_q.tx_state != TX_IDLE, s_q.tx_buf_full};
        default: s_d.rdata = 16'h0000;
      endcase
    end

    // Reading the receive word empties the buffer; a frame ending in
    // the same cycle sets the flags again below.
    if (rd_rx) begin
      s_d.rx_valid = 1'b0;
      s_d.rx_perr = 1'b0;
      s_d.rx_ferr = 1'b0;
      s_d.rx_ovr = 1'b0;
      if (s_q.rx_mode[IRQ_SRC_POS] && s_q.rx_valid) begin
        s_d.rx_irq = 1'b1;
      end
    end

    unique case (s_q.tx_state)
      TX_IDLE: begin
        s_d.txd = 1'b1;
        if (tx_on && s_q.tx_buf_full) begin
          s_d.tx_sh = s_q.tx_buf;
          s_d.tx_buf_full = 1'b0;
          s_d.tx_irq = s_q.tx_mode[IRQ_SRC_POS];
          s_d.tx_restart = 1'b1;
          s_d.txd = 1'b0;
          s_d.tx_state = TX_START;
        end
      end
      TX_START: begin
        if (tx_tick) begin
          s_d.tx_bit = 4'd0;
          s_d.txd = s_q.tx_sh[bit_pos(4'd0, len, lsb)];
          s_d.tx_state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_tick) begin
          if (s_q.tx_bit == len - 4'd1) begin
            s_d.tx_stop2 = (stop == STOP_TWO);
            if (par != PAR_NONE) begin
              s_d.tx_state = TX_PAR;
              unique case (par)
                PAR_ZERO: s_d.txd = 1'b0;
                PAR_EVEN: s_d.txd = odd_ones(s_q.tx_sh, len);
                default: s_d.txd = ~odd_ones(s_q.tx_sh, len);
              endcase
            end else if (stop != STOP_NONE) begin
              s_d.tx_state = TX_STOP;
              s_d.txd = 1'b1;
            end else begin
              s_d.tx_state = TX_IDLE;
              s_d.txd = 1'b1;
              s_d.tx_irq = ~s_q.tx_mode[IRQ_SRC_POS];
            end
          end else begin
            s_d.tx_bit = s_q.tx_bit + 4'd1;
            s_d.txd = s_q.tx_sh[bit_pos(s_q.tx_bit + 4'd1, len, lsb)];
          end
        end
      end
      TX_PAR: begin
        if (tx_tick) begin
          s_d.txd = 1'b1;
          if (stop != STOP_NONE) begin
            s_d.tx_state = TX_STOP;
          end else begin
            s_d.tx_state = TX_IDLE;
            s_d.tx_irq = ~s_q.tx_mode[IRQ_SRC_POS];
          end
        end
      end
      TX_STOP: begin
        if (tx_tick) begin
          if (s_q.tx_stop2) begin
            s_d.tx_stop2 = 1'b0;
          end else begin
            s_d.tx_state = TX_IDLE;
            s_d.tx_irq = ~s_q.tx_mode[IRQ_SRC_POS];
          end
        end
      end
      default: s_d.tx_state = TX_IDLE;
    endcase

    unique case (s_q.rx_state)
      RX_IDLE: begin
        // Edge trigger needs no arming; otherwise a software trigger.
        if (rx_on && (s_q.rx_armed || s_q.rx_mode[STS_POS]) &&
            s_q.line_prev && !line) begin
          s_d.rx_restart = 1'b1;
          s_d.rx_state = RX_START;
        end
      end
      RX_START: begin
        if (rx_mid) begin
          s_d.rx_bit = 4'd0;
          s_d.rx_sh = '0;
          s_d.rx_state = line ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_mid) begin
          s_d.rx_sh[bit_pos(s_q.rx_bit, len, lsb)] = line;
          s_d.rx_bit = s_q.rx_bit + 4'd1;
          s_d.rx_perr_now = 1'b0;
          s_d.rx_stop2 = (stop == STOP_TWO);
          if (s_q.rx_bit == len - 4'd1) begin
            if (par != PAR_NONE) begin
              s_d.rx_state = RX_PAR;
            end else if (stop != STOP_NONE) begin
              s_d.rx_state = RX_STOP;
            end else begin
              rx_done = 1'b1;
            end
          end
        end
      end
      RX_PAR: begin
        if (rx_mid) begin
          unique case (par)
            PAR_EVEN: s_d.rx_perr_now = odd_ones(s_q.rx_sh, len) ^ line;
            PAR_ODD: s_d.rx_perr_now = ~(odd_ones(s_q.rx_sh, len) ^ line);
            default: s_d.rx_perr_now = 1'b0;
          endcase
          if (stop != STOP_NONE) begin
            s_d.rx_state = RX_STOP;
          end else begin
            rx_done = 1'b1;
          end
        end
      end
      RX_STOP: begin
        if (rx_mid) begin
          if (!line) begin
            s_d.rx_ferr = 1'b1;
            s_d.err_irq = s_q.comm[EOC_POS];
          end
          if (s_q.rx_stop2) begin
            s_d.rx_stop2 = 1'b0;
          end else begin
            rx_done = 1'b1;
          end
        end
      end
      default: s_d.rx_state = RX_IDLE;
    endcase

    if (rx_done) begin
      s_d.rx_state = RX_IDLE;
      s_d.rx_data = s_d.rx_sh;
      s_d.rx_ovr = s_d.rx_ovr | (s_q.rx_valid && !rd_rx);
      s_d.rx_valid = 1'b1;
      s_d.rx_perr = s_d.rx_perr | s_d.rx_perr_now;
      if (s_d.rx_perr_now) begin
        s_d.err_irq = s_q.comm[EOC_POS];
      end
      s_d.rx_irq = s_d.rx_irq | ~s_q.rx_mode[IRQ_SRC_POS];
      s_d.rx_armed = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.tx_mode <= TX_MODE_RESET;
      s_q.comm <= TX_COMM_RESET;
      s_q.div <= TX_DIV_RESET[DIV_LO_POS +: DIV_W];
      s_q.rx_mode <= RX_MODE_RESET;
      s_q.tx_state <= TX_IDLE;
      s_q.rx_state <= RX_IDLE;
      s_q.s1 <= 1'b1;
      s_q.s2 <= 1'b1;
      s_q.s3 <= 1'b1;
      s_q.filt <= 1'b1;
      s_q.line_prev <= 1'b1;
      s_q.txd <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign txd = s_q.txd;
  assign tx_irq = s_q.tx_irq;
  assign rx_irq = s_q.rx_irq;
  assign receive_error_irq = s_q.err_irq;

endmodule

`default_nettype wire

//--- hw/scuc_pkg.sv
/*
  Shared constants and types of the serial channel configuration block:
  register indices, field positions, reset values, field codes and states.
  Assumes a 16-bit register port with a 3-bit word index.
*/
package scuc_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam int DIV_W = 7;
  localparam int CHAR_W = 9;

  localparam logic [2:0] OFS_TX_MODE = 3'h0;
  localparam logic [2:0] OFS_TX_COMM = 3'h1;
  localparam logic [2:0] OFS_TX_DATA_DIV = 3'h2;
  localparam logic [2:0] OFS_RX_MODE = 3'h3;
  localparam logic [2:0] OFS_RX_DATA = 3'h4;
  localparam logic [2:0] OFS_STATUS = 3'h5;

  localparam int MD_LO_POS = 1;
  localparam int IRQ_SRC_POS = 0;
  localparam int TXE_POS = 15;
  localparam int RXE_POS = 14;
  localparam int EOC_POS = 10;
  localparam int PTC_LO_POS = 8;
  localparam int DIR_POS = 7;
  localparam int SLC_LO_POS = 4;
  localparam int DLS_LO_POS = 0;
  localparam int DIV_LO_POS = 9;
  localparam int STS_POS = 8;
  localparam int SIS_POS = 6;
  localparam int SW_TRIG_POS = 0;
  localparam int RXD_PERR_POS = 9;
  localparam int RXD_FERR_POS = 10;
  localparam int RXD_OVR_POS = 11;
  localparam int RXD_VALID_POS = 15;

  localparam logic [15:0] TX_MODE_RESET = 16'h0022;
  localparam logic [15:0] TX_COMM_RESET = 16'h8297;
  localparam logic [15:0] TX_DIV_RESET = 16'h9a00;
  localparam logic [15:0] RX_MODE_RESET = 16'h0122;
  localparam logic [15:0] MODE_FIXED = 16'h0020;
  localparam logic [15:0] TX_MODE_WMASK = 16'h0007;
  localparam logic [15:0] RX_MODE_WMASK = 16'h0147;
  localparam logic [15:0] COMM_FIXED = 16'h0004;
  localparam logic [15:0] COMM_WMASK = 16'hc7b3;

  localparam logic [1:0] MODE_CLOCKED = 2'h0;
  localparam logic [1:0] MODE_ASYNC = 2'h1;
  localparam logic [1:0] MODE_TWO_WIRE = 2'h2;
  localparam logic [1:0] MODE_BAD = 2'h3;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  localparam logic [1:0] STOP_NONE = 2'h0;
  localparam logic [1:0] STOP_TWO = 2'h2;
  localparam logic [1:0] STOP_BAD = 2'h3;
  localparam logic [1:0] LEN_NINE = 2'h1;
  localparam logic [1:0] LEN_SEVEN = 2'h2;
  localparam logic [1:0] LEN_BAD = 2'h0;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
  } scuc_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } scuc_rx_state_t;

endpackage

//--- hw/scuc_bit_timer.sv
/*
  Bit timer: divides the channel operation clock by twice the divisor
  plus two and pulses at the middle of every bit period and two cycles
  before its end, so a line registered on tick flips on the boundary.
  Assumes the divisor is held steady while a frame is in flight.
*/
`timescale 1ns/1ps
`default_nettype none

module scuc_bit_timer
  import scuc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic restart,
  input wire logic [scuc_pkg::DIV_W-1:0] divisor,
  output logic tick,
  output logic mid
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
    logic mid;
  } scuc_tmr_t;

  scuc_tmr_t s_q;
  scuc_tmr_t s_d;
  logic [7:0] last;
  logic [7:0] tick_at;

  // Period is 2*(divisor+1) cycles: divisions 2 to 256.
  assign last = {divisor, 1'b1};
  // The restart reaches the counter a cycle late and the caller registers
  // its line a cycle after tick, so tick leads the period end by two.
  // With a divisor of zero the first bit after a restart lasts 4 cycles.
  assign tick_at = (last > 8'h02) ? last - 8'h02 : last;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.mid = 1'b0;
    if (restart || s_q.cnt == last) begin
      s_d.cnt = 8'h00;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
    if (!restart) begin
      s_d.tick = (s_q.cnt == tick_at);
      s_d.mid = (s_q.cnt == {1'b0, divisor});
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
  assign mid = s_q.mid;

endmodule

`default_nettype wire

//--- sim/scuc_props.sv
/*
  Port checker for scuc_top: keeps shadow copies of the written config.
  Assumes it is bound to scuc_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module scuc_props
  import scuc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [scuc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [scuc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [scuc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic txd,
  input wire logic rxd,
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic receive_error_irq
);
  logic [15:0] mode_q, comm_q, rxm_q;
  logic [6:0] div_q;
  logic txd_q;
  logic [11:0] run_q;
  int per;
  assign per = 2 * (int'(div_q) + 1);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= TX_MODE_RESET;
      comm_q <= TX_COMM_RESET;
      rxm_q <= RX_MODE_RESET;
      div_q <= 7'h4d;
      txd_q <= 1'b1;
      run_q <= 12'h0;
    end else begin
      txd_q <= txd;
      run_q <= (txd != txd_q) ? 12'h1 : run_q + 12'h1;
      if (reg_wr && reg_addr == OFS_TX_MODE)
        mode_q <= (reg_wdata & TX_MODE_WMASK) | MODE_FIXED;
      if (reg_wr && reg_addr == OFS_TX_COMM)
        comm_q <= (reg_wdata & COMM_WMASK) | COMM_FIXED;
      if (reg_wr && reg_addr == OFS_RX_MODE)
        rxm_q <= (reg_wdata & RX_MODE_WMASK) | MODE_FIXED;
      if (reg_wr && reg_addr == OFS_TX_DATA_DIV)
        div_q <= reg_wdata[15:9];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 16'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle zero");
  property p_txmode_rd;
    $past(reg_rd && reg_addr == OFS_TX_MODE) |-> reg_rdata == $past(mode_q);
  endproperty
  a_txmode_rd: assert property (p_txmode_rd)
    else $error("tx mode readback wrong");
  property p_comm_rd;
    $past(reg_rd && reg_addr == OFS_TX_COMM) |-> reg_rdata == $past(comm_q);
  endproperty
  a_comm_rd: assert property (p_comm_rd)
    else $error("control readback wrong");
  property p_div_rd;
    $past(reg_rd && reg_addr == OFS_TX_DATA_DIV)
      |-> reg_rdata[15:9] == $past(div_q);
  endproperty
  a_div_rd: assert property (p_div_rd)
    else $error("divisor readback wrong");
  property p_rxmode_rd;
    $past(reg_rd && reg_addr == OFS_RX_MODE) |-> reg_rdata == $past(rxm_q);
  endproperty
  a_rxmode_rd: assert property (p_rxmode_rd)
    else $error("rx mode readback wrong");
  property p_unmapped;
    $past(reg_rd && reg_addr > OFS_STATUS) |-> reg_rdata == 16'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
  property p_start_cfg;
    $fell(txd) |-> comm_q[TXE_POS] && mode_q[2:1] == MODE_ASYNC;
  endproperty
  a_start_cfg: assert property (p_start_cfg)
    else $error("txd moved while transmit disabled");
  property p_bit_time;
    txd && !txd_q |-> int'(run_q) % per == 0;
  endproperty
  a_bit_time: assert property (p_bit_time)
    else $error("low run not whole bit periods");
  property p_err_mask;
    !comm_q[EOC_POS] && !$past(comm_q[EOC_POS]) |-> !receive_error_irq;
  endproperty
  a_err_mask: assert property (p_err_mask)
    else $error("error irq while masked");
  property p_tx_pulse;
    tx_irq |=> !tx_irq;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse)
    else $error("tx irq longer than a pulse");
  property p_rx_pulse;
    rx_irq |=> !rx_irq;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("rx irq longer than a pulse");
  property p_tx_end;
    tx_irq && !mode_q[IRQ_SRC_POS] && comm_q[5:4] != STOP_NONE
      |-> txd && $past(txd, 2);
  endproperty
  a_tx_end: assert property (p_tx_end)
    else $error("end irq before stop bits");
endmodule
bind scuc_top scuc_props u_props (.clk_sys, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .txd, .rxd, .tx_irq, .rx_irq,
  .receive_error_irq);
`default_nettype wire

//--- sim/scuc_remote.sv
/*
  Remote serial device: sends frames on rxd and samples frames on txd.
  Assumes the caller passes the bit period in clk_sys cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module scuc_remote (
  input wire logic clk_sys,
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;
  // Element 0 of bits goes first; the line idles high afterwards.
  task automatic send(input logic [15:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (per) @(posedge clk_sys);
    end
    rxd <= 1'b1;
  endtask
  task automatic grab(input int n, input int per, output logic [15:0] bits);
    int w;
    bits = 16'h0;
    w = 0;
    while (txd !== 1'b0 && w < 3000) begin
      @(posedge clk_sys);
      w++;
    end
    repeat (per / 2) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      repeat (per) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
/*
  Self-checking bench for scuc_top with a remote serial partner.
  Assumes a divisor of 3, so one bit lasts 8 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scuc_pkg::*;
  typedef struct packed {
    logic wr;
    logic [2:0] a;
    logic [15:0] d;
    logic [15:0] e;
    logic [15:0] m;
  } scuc_row_t;
  localparam int PER = 8;
  localparam logic [6:0] DIV = 7'h3;
  logic clk_sys, rst, reg_wr, reg_rd, txd, rxd;
  logic tx_irq, rx_irq, receive_error_irq, saw_tx, saw_rx, saw_err;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_v, fb, got, exp_rx;
  int err_count, num_checks, cyc, n;
  logic [8:0] msk;
  scuc_row_t rtab[9];
  logic [15:0] fc[4] = '{16'hc097, 16'hc216, 16'hc3a5, 16'hc113};
  logic [8:0] fd[4] = '{9'h0a5, 9'h05b, 9'h1c3, 9'h0f0};
  scuc_top uut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .txd, .rxd, .tx_irq, .rx_irq, .receive_error_irq);
  scuc_remote u_remote (.clk_sys, .txd, .rxd);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (tx_irq) saw_tx <= 1'b1;
    if (rx_irq) saw_rx <= 1'b1;
    if (receive_error_irq) saw_err <= 1'b1;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    v = reg_rdata;
  endtask
  // Builds the expected line bits, start bit first.
  function automatic void mk(input logic [15:0] c, input logic [8:0] d);
    int len;
    len = (c[1:0] == LEN_NINE) ? 9 : (c[1:0] == LEN_SEVEN) ? 7 : 8;
    msk = 9'((1 << len) - 1);
    fb = 16'h0;
    n = 1;
    for (int i = 0; i < len; i++) begin
      fb[n] = c[DIR_POS] ? d[i] : d[len - 1 - i];
      n++;
    end
    if (c[9:8] != PAR_NONE) begin
      fb[n] = (c[9:8] == PAR_EVEN) ? ^(d & msk) :
              (c[9:8] == PAR_ODD) ? ~^(d & msk) : 1'b0;
      n++;
    end
    for (int i = 0; i < int'(c[5:4]); i++) begin
      fb[n] = 1'b1;
      n++;
    end
    exp_rx = 16'h8000 | 16'(d & msk);
  endfunction
  task automatic txrx(input logic [15:0] c, input logic [8:0] d,
                      input logic [15:0] flip);
    mk(c, d);
    wr(OFS_TX_COMM, c);
    wr(OFS_TX_DATA_DIV, {DIV, d});
    u_remote.grab(n, PER, got);
    chk(got, fb);
    saw_rx <= 1'b0;
    saw_err <= 1'b0;
    u_remote.send(fb ^ flip, n, PER);
    for (int w = 0; w < 4 * PER && !saw_rx; w++) @(posedge clk_sys);
    rd(OFS_RX_DATA, rd_v);
  endtask
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0;
    err_count = 0;
    num_checks = 0;
    cyc = 0;
    saw_tx = 1'b0;
    saw_rx = 1'b0;
    saw_err = 1'b0;
    rtab[0] = '{1'b0, OFS_TX_MODE, 16'h0, 16'h0022, 16'hffff};
    rtab[1] = '{1'b0, OFS_TX_COMM, 16'h0, 16'h8297, 16'hffff};
    rtab[2] = '{1'b0, OFS_TX_DATA_DIV, 16'h0, 16'h9a00, 16'hfe00};
    rtab[3] = '{1'b0, OFS_RX_MODE, 16'h0, 16'h0122, 16'hffff};
    rtab[4] = '{1'b1, OFS_TX_MODE, 16'hffff, 16'h0027, 16'hffff};
    rtab[5] = '{1'b1, OFS_TX_COMM, 16'hffff, 16'hc7b7, 16'hffff};
    rtab[6] = '{1'b1, OFS_RX_MODE, 16'hffff, 16'h0167, 16'hffff};
    rtab[7] = '{1'b1, 3'h6, 16'hffff, 16'h0, 16'hffff};
    rtab[8] = '{1'b0, 3'h7, 16'h0, 16'h0, 16'hffff};
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (rtab[i]) begin
      if (rtab[i].wr) wr(rtab[i].a, rtab[i].d);
      rd(rtab[i].a, rd_v);
      chk(rd_v & rtab[i].m, rtab[i].e);
    end
    wr(OFS_TX_MODE, 16'h0002);
    wr(OFS_RX_MODE, 16'h0102);
    for (int i = 0; i < 4; i++) begin
      txrx(fc[i], fd[i], 16'h0);
      chk(rd_v, exp_rx);
    end
    // Flipped parity with the error interrupt enabled.
    txrx(16'hc616, 9'h05b, 16'h0100);
    chk(rd_v & 16'h8600, 16'h8200);
    chk(16'(saw_err), 16'h1);
    // Low stop bit with the error interrupt masked.
    txrx(16'hc216, 9'h05b, 16'h0200);
    chk(rd_v & 16'h8600, 16'h8400);
    chk(16'(saw_err), 16'h0);
    // Edge start disarmed: only the software trigger starts reception.
    wr(OFS_RX_MODE, 16'h0002);
    mk(16'hc216, 9'h05b);
    saw_rx <= 1'b0;
    u_remote.send(fb, n, PER);
    repeat (2 * PER) @(posedge clk_sys);
    chk(16'(saw_rx), 16'h0);
    wr(OFS_STATUS, 16'h0001);
    u_remote.send(fb, n, PER);
    repeat (2 * PER) @(posedge clk_sys);
    chk(16'(saw_rx), 16'h1);
    rd(OFS_RX_DATA, rd_v);
    chk(rd_v, exp_rx);
    // Prohibited mode holds the buffer; a legal mode then sends it.
    wr(OFS_TX_MODE, 16'h0006);
    wr(OFS_TX_DATA_DIV, {DIV, 9'h055});
    repeat (3 * PER) @(posedge clk_sys);
    rd(OFS_STATUS, rd_v);
    chk(rd_v & 16'h0005, 16'h0005);
    saw_tx <= 1'b0;
    wr(OFS_TX_MODE, 16'h0003);
    repeat (4) @(posedge clk_sys);
    chk(16'(saw_tx), 16'h1);
    repeat (15 * PER) @(posedge clk_sys);
    rd(OFS_STATUS, rd_v);
    chk(rd_v & 16'h0001, 16'h0);
    final_report();
  end
endmodule
`default_nettype wire
